// [rtl/gie_core.sv]
`include "gie_defs.svh"

module gio_core (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction boundary from the core
    input wire logic instr_valid,
    input wire gio_pkg::gio_op_type instr_op,
    // Interrupt request pins
    input wire logic irq_req,
    input wire logic nmi_req,
    // Interrupt decisions and status
    output logic irq_accept,
    output logic nmi_accept,
    output logic global_irq_enable_bit,
    output logic [15:0] status_word,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    gio_pkg::gio_state_type st;
    gio_pkg::gio_state_type next_st;
    logic irq_lvl;
    logic nmi_lvl;
    logic wr_fire;
    logic wr_status;

    gio_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({nmi_req, irq_req}),
        .level({nmi_lvl, irq_lvl})
    );

    assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
    assign wr_status = wr_fire && (st.aw_addr == `GIO_OFS_STATUS);

    always_comb begin
        next_st = st;
        next_st.irq_accept = 1'b0;
        next_st.nmi_accept = 1'b0;
        // Write channels taken in either order
        if (awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awready = 1'b0;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wready = 1'b0;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_status ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
            if (wr_status) begin
                if (st.w_strb[0]) begin
                    next_st.status_word[7:0] = st.w_data[7:0];
                end
                if (st.w_strb[1]) begin
                    next_st.status_word[15:8] = st.w_data[15:8];
                end
            end
        end
        // Read channel
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = `GIO_RESP_OKAY;
            unique case (araddr)
                `GIO_OFS_STATUS: next_st.rdata = {16'h0000, st.status_word};
                `GIO_OFS_CORE: next_st.rdata = {28'h0000000, nmi_lvl, irq_lvl,
                    st.ei_shadow, st.status_word[`GIO_BIT_EN]};
                `GIO_OFS_COUNT: next_st.rdata = {16'h0000, st.accept_count};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = `GIO_RESP_SLVERR;
                end
            endcase
        end
        // Instruction boundary
        if (instr_valid) begin
            if (irq_lvl && st.status_word[`GIO_BIT_EN] && !st.ei_shadow) begin
                next_st.irq_accept = 1'b1;
                next_st.accept_count = 16'(st.accept_count + 16'h0001);
            end
            next_st.nmi_accept = nmi_lvl;
            next_st.ei_shadow = (instr_op == gio_pkg::GIO_OP_ENABLE);
            unique case (instr_op)
                gio_pkg::GIO_OP_DISABLE: begin
                    next_st.status_word = next_st.status_word & ~`GIO_EN_MASK;
                end
                gio_pkg::GIO_OP_ENABLE: begin
                    next_st.status_word = next_st.status_word | `GIO_EN_MASK;
                end
                gio_pkg::GIO_OP_NONE, gio_pkg::GIO_OP_OTHER: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.status_word <= `GIO_STATUS_RESET;
            st.accept_count <= `GIO_COUNT_RESET;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign irq_accept = st.irq_accept;
    assign nmi_accept = st.nmi_accept;
    assign global_irq_enable_bit = st.status_word[`GIO_BIT_EN];
    assign status_word = st.status_word;
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_DIS_CLEARS: assert property (
        instr_valid && instr_op == gio_pkg::GIO_OP_DISABLE && !wr_status
        |=> !global_irq_enable_bit)
        else $error("Disable op left enable bit set");
    AST_EN_SETS: assert property (
        instr_valid && instr_op == gio_pkg::GIO_OP_ENABLE && !wr_status
        |=> global_irq_enable_bit)
        else $error("Enable op left enable bit clear");
    AST_FLAGS_KEPT: assert property (
        instr_valid && instr_op[1] && !wr_status
        |=> (status_word & `GIO_FLAG_MASK) == ($past(status_word) & `GIO_FLAG_MASK))
        else $error("Flags changed by enable or disable op");
    AST_DIS_MODES: assert property (
        instr_valid && instr_op == gio_pkg::GIO_OP_DISABLE && !wr_status
        |=> (status_word & `GIO_MODE_MASK) == ($past(status_word) & `GIO_MODE_MASK))
        else $error("Disable op changed mode bits");
    AST_EN_MODES: assert property (
        instr_valid && instr_op == gio_pkg::GIO_OP_ENABLE && !wr_status
        |=> (status_word & `GIO_MODE_MASK) == ($past(status_word) & `GIO_MODE_MASK))
        else $error("Enable op changed mode bits");
    AST_SHADOW_SET: assert property (
        instr_valid && instr_op == gio_pkg::GIO_OP_ENABLE |=> st.ei_shadow)
        else $error("Enable op did not arm the shadow");
    AST_EN_SHADOW: assert property (
        instr_valid && st.ei_shadow |=> !irq_accept)
        else $error("Interrupt taken before instruction after enable");
    AST_MASK_GATE: assert property (
        irq_accept |-> $past(global_irq_enable_bit) && $past(irq_lvl)
        && $past(instr_valid) && !$past(st.ei_shadow))
        else $error("Maskable accepted without enable bit");
    AST_IRQ_TAKEN: assert property (
        instr_valid && irq_lvl && global_irq_enable_bit && !st.ei_shadow |=> irq_accept)
        else $error("Maskable not accepted while enabled");
    AST_NMI_TAKEN: assert property (
        instr_valid && nmi_lvl && !global_irq_enable_bit |=> nmi_accept)
        else $error("Non-maskable not accepted");
    AST_RD_ANSWER: assert property (
        arvalid && arready |=> rvalid && !arready)
        else $error("Read not answered one cycle after address");
    AST_WR_ANSWER: assert property (
        wr_fire |=> bvalid && awready && wready)
        else $error("Write not answered after both channels taken");

    COV_IRQ: cover property (irq_accept);
    COV_NMI: cover property (nmi_accept && !global_irq_enable_bit);
    COV_EN_PENDING: cover property (
        instr_valid && instr_op == gio_pkg::GIO_OP_ENABLE && irq_lvl ##1 instr_valid);
    COV_BUS_WRITE: cover property (wr_status);
    COV_SHADOW_HOLD: cover property (
        instr_valid && st.ei_shadow && irq_lvl && global_irq_enable_bit);
endmodule // gio_core

// [rtl/gie_defs.svh]
`ifndef GIO_DEFS_SVH
`define GIO_DEFS_SVH

// Register byte offsets
`define GIO_OFS_STATUS 4'h0
`define GIO_OFS_CORE 4'h4
`define GIO_OFS_COUNT 4'h8

// Status word field positions
`define GIO_BIT_C 0
`define GIO_BIT_Z 1
`define GIO_BIT_N 2
`define GIO_BIT_EN 3
`define GIO_BIT_HALT 4
`define GIO_BIT_OSC_STOP 5
`define GIO_BIT_V 8

// Masks and reset values
`define GIO_EN_MASK 16'h0008
`define GIO_FLAG_MASK 16'h0107
`define GIO_MODE_MASK 16'h0030
`define GIO_STATUS_RESET 16'h0000
`define GIO_COUNT_RESET 16'h0000

// Bus responses
`define GIO_RESP_OKAY 2'h0
`define GIO_RESP_SLVERR 2'h2

`endif

// [rtl/gie_pkg.sv]
package gio_pkg;

    typedef enum logic [1:0] {
        GIO_OP_NONE = 2'h0,
        GIO_OP_OTHER = 2'h1,
        GIO_OP_ENABLE = 2'h2,
        GIO_OP_DISABLE = 2'h3
    } gio_op_type;

    typedef struct packed {
        logic [15:0] status_word;
        logic ei_shadow;
        logic irq_accept;
        logic nmi_accept;
        logic [15:0] accept_count;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [3:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gio_state_type;

endpackage

// [rtl/gie_sync.sv]
module gio_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;

    // Change counts once second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            level <= '0;
        end else begin
            ff1 <= async_in;
            ff2 <= ff1;
            ff3 <= ff2;
            for (int i = 0; i < WIDTH; i++) begin
                if (ff2[i] == ff3[i]) begin
                    level[i] <= ff3[i];
                end
            end
        end
    end
endmodule // gio_sync

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic instr_valid = 1'b0;
    gio_pkg::gio_op_type instr_op = gio_pkg::GIO_OP_NONE;
    logic irq_req = 1'b0;
    logic nmi_req = 1'b0;
    logic irq_accept, nmi_accept, global_irq_enable_bit;
    logic [15:0] status_word;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int failures = 0;
    int num_checks = 0;
    logic [1:0] resp;
    logic [31:0] data;
    logic acc, nmi;
    logic [15:0] start_vals [4] = '{16'h0137, 16'h0000, 16'h013f, 16'h0030};

    gio_core uut (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
        .instr_op(instr_op), .irq_req(irq_req), .nmi_req(nmi_req),
        .irq_accept(irq_accept), .nmi_accept(nmi_accept),
        .global_irq_enable_bit(global_irq_enable_bit), .status_word(status_word),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h3),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bready && bvalid;
            if (b_ok) resp = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end while (!b_ok);
    endtask

    task automatic axi_read(input logic [3:0] a);
        logic ar_ok, r_ok;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rready && rvalid;
            if (r_ok) data = rdata;
            if (r_ok) resp = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end while (!r_ok);
    endtask

    task automatic step(input gio_pkg::gio_op_type op);
        @(posedge aclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        @(posedge aclk);
        instr_valid <= 1'b0;
        instr_op <= gio_pkg::GIO_OP_NONE;
        #1;
        acc = irq_accept;
        nmi = nmi_accept;
    endtask

    task automatic stop_test();
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(status_word, 32'h0);
        foreach (start_vals[i]) begin
            axi_write(4'h0, {16'h0, start_vals[i]});
            step(gio_pkg::GIO_OP_ENABLE);
            chk(status_word, start_vals[i] | 16'h0008);
            chk(global_irq_enable_bit, 1'b1);
            step(gio_pkg::GIO_OP_DISABLE);
            chk(status_word, start_vals[i] & 16'hfff7);
            chk(global_irq_enable_bit, 1'b0);
            axi_read(4'h0);
            chk(data, {16'h0, start_vals[i] & 16'hfff7});
        end
        axi_write(4'h0, 32'h0);
        irq_req <= 1'b1;
        repeat (6) @(posedge aclk);
        step(gio_pkg::GIO_OP_OTHER);
        chk(acc, 1'b0);
        step(gio_pkg::GIO_OP_ENABLE);
        chk(acc, 1'b0);
        step(gio_pkg::GIO_OP_OTHER);
        chk(acc, 1'b0);
        step(gio_pkg::GIO_OP_OTHER);
        chk(acc, 1'b1);
        step(gio_pkg::GIO_OP_DISABLE);
        chk(acc, 1'b1);
        step(gio_pkg::GIO_OP_OTHER);
        chk(acc, 1'b0);
        nmi_req <= 1'b1;
        repeat (6) @(posedge aclk);
        step(gio_pkg::GIO_OP_OTHER);
        chk({acc, nmi}, 2'b01);
        axi_read(4'h8);
        chk(data, 32'h2);
        axi_read(4'h4);
        chk(data, 32'hc);
        axi_read(4'hc);
        chk(resp, 2'h2);
        chk(data, 32'h0);
        axi_write(4'h4, 32'hf);
        chk(resp, 2'h2);
        axi_write(4'hc, 32'hf);
        chk(resp, 2'h2);
        axi_read(4'h0);
        chk(resp, 2'h0);
        chk(data, 32'h0);
        axi_write(4'h0, 32'h0137);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(status_word, 32'h0);
        axi_read(4'h8);
        chk(data, 32'h0);
        stop_test();
    end
endmodule // tb
